// ### core/fault_channel.v
// one supervised fault channel: hysteresis comparator and consecutive counter
`timescale 1ns/1ps
`include "power_fault_defs.vh"
module fault_channel #(
  parameter W = 12,
  parameter CW = 4
) (
  input wire clk,
  input wire rst,
  input wire sample_en,
  input wire [W-1:0] value,
  input wire [W-1:0] limit,
  input wire [W-1:0] hyst,
  input wire over_mode,
  input wire [CW-1:0] need,
  output reg comp_q,
  output reg fault_q
);
  reg [CW:0] cnt_q;
  wire [W:0] lim_x = {1'b0, limit};
  wire [W:0] val_x = {1'b0, value};
  wire [W:0] hys_x = {1'b0, hyst};
  reg comp_d;
  // comparator only releases once the signal is a full hysteresis back inside
  always @* begin
    comp_d = comp_q;
    if (over_mode) begin
      if (val_x > lim_x) comp_d = 1'b1;
      else if (val_x + hys_x <= lim_x) comp_d = 1'b0;
    end else begin
      if (val_x < lim_x) comp_d = 1'b1;
      else if (val_x >= lim_x + hys_x) comp_d = 1'b0;
    end
  end
  // count consecutive out-of-limit samples
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      comp_q <= 1'b0;
      cnt_q <= {(CW+1){1'b0}};
      fault_q <= 1'b0;
    end else if (sample_en) begin
      comp_q <= comp_d;
      if (!comp_d) begin
        cnt_q <= {(CW+1){1'b0}};
        fault_q <= 1'b0;
      end else if (cnt_q < {1'b0, need}) begin
        cnt_q <= cnt_q + 1'b1;
      end else begin
        fault_q <= 1'b1;
      end
    end
  end
endmodule

// ### core/fault_response.v
// response sequencer for one fault: ignore, delay then stop, retries
`timescale 1ns/1ps
`include "power_fault_defs.vh"
module fault_response #(
  parameter DW = 24
) (
  input wire clk,
  input wire rst,
  input wire tick,
  input wire fault,
  input wire [1:0] resp,
  input wire [2:0] retries,
  input wire [7:0] delay_cnt,
  input wire [3:0] unit_sel,
  input wire reenable,
  output reg run_q,
  output reg latched_q
);
  localparam S_RUN = 2'h0;
  localparam S_GRACE = 2'h1;
  localparam S_WAIT = 2'h2;
  localparam S_LATCH = 2'h3;
  reg [1:0] st_q;
  reg [DW-1:0] tmr_q;
  reg [2:0] tries_q;
  // delay in ticks of the base unit; unit select doubles per step, clamped at the 256 unit
  wire [3:0] sel_c = (unit_sel > `UNIT_SEL_MAX) ? `UNIT_SEL_MAX : unit_sel;
  wire [DW-1:0] dly = {{(DW-8){1'b0}}, delay_cnt} << sel_c;
  wire [DW-1:0] dly1 = (dly == {DW{1'b0}}) ? {{(DW-1){1'b0}}, 1'b1} : dly;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= S_RUN;
      tmr_q <= {DW{1'b0}};
      tries_q <= 3'h0;
      run_q <= 1'b1;
      latched_q <= 1'b0;
    end else begin
      case (st_q)
        S_RUN: begin
          run_q <= 1'b1;
          if (fault && resp != `RESP_IGNORE) begin
            tmr_q <= dly1;
            if (resp == `RESP_DELAY) begin
              st_q <= S_GRACE;
            end else begin
              run_q <= 1'b0;
              st_q <= S_WAIT;
            end
          end
        end
        S_GRACE: begin
          if (tick) tmr_q <= tmr_q - 1'b1;
          if (tick && tmr_q == {{(DW-1){1'b0}}, 1'b1}) begin
            run_q <= 1'b0;
            tmr_q <= dly1;
            st_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (retries != `RETRY_CONT && tries_q >= retries) begin
            latched_q <= 1'b1;
            st_q <= S_LATCH;
          end else begin
            if (tick) tmr_q <= tmr_q - 1'b1;
            if (tick && tmr_q == {{(DW-1){1'b0}}, 1'b1}) begin
              if (retries != `RETRY_CONT) tries_q <= tries_q + 1'b1;
              run_q <= 1'b1;
              st_q <= S_RUN;
            end
          end
        end
        S_LATCH: begin
          run_q <= 1'b0;
          if (reenable) begin
            latched_q <= 1'b0;
            tries_q <= 3'h0;
            st_q <= S_RUN;
          end
        end
        default: st_q <= S_RUN;
      endcase
    end
  end
endmodule

// ### core/power_fault_defs.vh
// timing counts, response codes and reset values for the fault protection block
// Operation
// - action delay equals count times scale unit
// - delays reach count 128 at 256 ms
// - code 01 runs for delay, then stops
// - input current uses input voltage unit
// - per fault response, retries, retry delay
// - fault asserts after consecutive detections only
// - comparators carry programmable hardware hysteresis
// - common faults ignore or shut down
// - short circuit trips on one sample
// - zero short circuit threshold disables detection
// - fast overcurrent needs programmed plus one
// - fast overcurrent adds one cycle latency
// - unlock read reports password set; reads zero here once the correct password unlocks
// - correct password clears write protection
// - protected writes refused, status flags invalid
// - changes live in RAM until committed
`ifndef POWER_FAULT_DEFS_VH
`define POWER_FAULT_DEFS_VH
// ==================================================
// clock and time base
`define CLK_HZ 10000000
`define UNIT_BASE_US 1000
`define UNIT_BASE_CYC ((`CLK_HZ / 1000000) * `UNIT_BASE_US)
`define DELAY_CNT_MAX 128
`define UNIT_SEL_MAX 4'h8
// ==================================================
// response codes
`define RESP_IGNORE 2'h0
`define RESP_DELAY 2'h1
`define RESP_SHUT 2'h2
`define RESP_SHUT2 2'h3
`define RETRY_CONT 3'h7
// ==================================================
// security
`define UNLOCK_ACTIVE 48'h000000000001
`define UNLOCK_NONE 48'h000000000000
`endif

// ### core/power_fault_protection.v
// fault supervision top: fault channels, short circuit, fast overcurrent, security
`timescale 1ns/1ps
`include "power_fault_defs.vh"
module power_fault_protection #(
  parameter NF = 4,
  parameter W = 12,
  parameter CW = 4,
  parameter NCMD = 16
) (
  input wire clk,
  input wire rst,
  input wire sample_en,
  input wire sw_cycle,
  input wire [NF*W-1:0] fault_value,
  input wire [NF*W-1:0] fault_limit,
  input wire [NF*W-1:0] fault_hyst,
  input wire [NF-1:0] fault_over,
  input wire [NF*CW-1:0] fault_need,
  input wire [NF*2-1:0] fault_resp,
  input wire [NF*3-1:0] fault_retries,
  input wire [NF*8-1:0] fault_delay,
  input wire [NF-1:0] fault_is_iin,
  input wire [NF-1:0] fault_is_vin,
  input wire [3:0] vin_unit_sel,
  input wire [3:0] other_unit_sel,
  input wire [W-1:0] current_sample,
  input wire [W-1:0] short_circuit_threshold,
  input wire [W-1:0] fast_overcurrent_limit,
  input wire [3:0] fast_overcurrent_count,
  input wire [4:0] common_fault_in,
  input wire [4:0] common_shutdown_en,
  input wire reenable,
  input wire cmd_wr,
  input wire [7:0] cmd_idx,
  input wire [47:0] cmd_data,
  input wire [7:0] unlock_idx,
  input wire [7:0] setpw_idx,
  input wire [NCMD-1:0] write_protect_mask,
  input wire commit,
  output reg [47:0] unlock_read_q,
  output reg cmd_accept_q,
  output reg cml_invalid_q,
  output reg [47:0] ram_data_q,
  output reg [7:0] ram_idx_q,
  output reg ram_wr_q,
  output reg otp_commit_q,
  output reg [NF-1:0] fault_flag_q,
  output reg short_circuit_q,
  output reg fast_oc_q,
  output reg converter_on_q,
  output reg [NF-1:0] latched_q
);
  // ================================================
  // millisecond tick from the system clock
  reg [15:0] ms_q;
  reg tick_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (ms_q == `UNIT_BASE_CYC - 1) begin
      ms_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      ms_q <= ms_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end
  // ================================================
  // supervised fault channels
  wire [NF-1:0] ch_fault;
  wire [NF-1:0] ch_run;
  wire [NF-1:0] ch_latch;
  genvar i;
  generate
    for (i = 0; i < NF; i = i + 1) begin : g_ch
      // input current borrows the input voltage scale unit
      wire [3:0] usel = (fault_is_iin[i] | fault_is_vin[i]) ? vin_unit_sel : other_unit_sel;
      fault_channel #(.W(W), .CW(CW)) u_ch (
        .clk(clk),
        .rst(rst),
        .sample_en(sample_en),
        .value(fault_value[i*W +: W]),
        .limit(fault_limit[i*W +: W]),
        .hyst(fault_hyst[i*W +: W]),
        .over_mode(fault_over[i]),
        .need(fault_need[i*CW +: CW]),
        .comp_q(),
        .fault_q(ch_fault[i])
      );
      fault_response u_rsp (
        .clk(clk),
        .rst(rst),
        .tick(tick_q),
        .fault(ch_fault[i]),
        .resp(fault_resp[i*2 +: 2]),
        .retries(fault_retries[i*3 +: 3]),
        .delay_cnt(fault_delay[i*8 +: 8]),
        .unit_sel(usel),
        .reenable(reenable),
        .run_q(ch_run[i]),
        .latched_q(ch_latch[i])
      );
    end
  endgenerate
  // ================================================
  // short circuit: single sample, no counting; zero threshold disables
  // only a fresh sample may trip, a held stale value between samples must not
  wire sc_hit = sample_en && (short_circuit_threshold != {W{1'b0}}) &&
    (current_sample > short_circuit_threshold);
  // ================================================
  // fast overcurrent counted per switching cycle, one extra cycle of latency
  reg [4:0] foc_cnt_q;
  reg foc_reached_q;
  reg foc_over_q;
  // track whether any sample exceeded the fast limit during this switching cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      foc_over_q <= 1'b0;
    end else if (sw_cycle) begin
      foc_over_q <= 1'b0;
    end else if (sample_en && current_sample > fast_overcurrent_limit) begin
      foc_over_q <= 1'b1;
    end
  end
  wire foc_cycle_over = foc_over_q | (sample_en && current_sample > fast_overcurrent_limit);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      foc_cnt_q <= 5'h00;
      foc_reached_q <= 1'b0;
      fast_oc_q <= 1'b0;
    end else if (sw_cycle) begin
      fast_oc_q <= foc_reached_q;
      if (!foc_cycle_over) begin
        foc_cnt_q <= 5'h00;
        foc_reached_q <= 1'b0;
      end else if (foc_cnt_q < {1'b0, fast_overcurrent_count}) begin
        foc_cnt_q <= foc_cnt_q + 5'h01;
      end else begin
        foc_reached_q <= 1'b1;
      end
    end
  end
  // ================================================
  // common faults and overall converter enable
  wire [4:0] common_now = {common_fault_in[4:2], fast_oc_q, sc_hit | common_fault_in[0]};
  wire common_shut = |(common_now & common_shutdown_en);
  reg common_latch_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      common_latch_q <= 1'b0;
      short_circuit_q <= 1'b0;
      fault_flag_q <= {NF{1'b0}};
      latched_q <= {NF{1'b0}};
      converter_on_q <= 1'b0;
    end else begin
      short_circuit_q <= sc_hit;
      fault_flag_q <= ch_fault;
      latched_q <= ch_latch;
      if (common_shut) common_latch_q <= 1'b1;
      else if (reenable) common_latch_q <= 1'b0;
      converter_on_q <= (&ch_run) & ~common_shut & ~common_latch_q;
    end
  end
  // ================================================
  // password protection of command writes
  reg [47:0] pw_q;
  reg pw_set_q;
  reg secure_q;
  wire [NCMD-1:0] cmd_bit = {{(NCMD-1){1'b0}}, 1'b1} << cmd_idx[3:0];
  wire cmd_protected = (cmd_idx < NCMD) && |(cmd_bit & write_protect_mask);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pw_q <= 48'h000000000000;
      pw_set_q <= 1'b0;
      secure_q <= 1'b0;
      cmd_accept_q <= 1'b0;
      cml_invalid_q <= 1'b0;
      ram_wr_q <= 1'b0;
      ram_idx_q <= 8'h00;
      ram_data_q <= 48'h000000000000;
      otp_commit_q <= 1'b0;
      unlock_read_q <= `UNLOCK_NONE;
    end else begin
      cmd_accept_q <= 1'b0;
      cml_invalid_q <= 1'b0;
      ram_wr_q <= 1'b0;
      otp_commit_q <= commit;
      unlock_read_q <= (pw_set_q && secure_q) ? `UNLOCK_ACTIVE : `UNLOCK_NONE;
      if (cmd_wr) begin
        if (cmd_idx == unlock_idx) begin
          if (pw_set_q && cmd_data == pw_q) secure_q <= 1'b0;
          cmd_accept_q <= 1'b1;
        end else if (secure_q && cmd_protected) begin
          cml_invalid_q <= 1'b1;
        end else if (cmd_idx == setpw_idx) begin
          pw_q <= cmd_data;
          pw_set_q <= (cmd_data != 48'h000000000000);
          secure_q <= (cmd_data != 48'h000000000000);
          cmd_accept_q <= 1'b1;
        end else begin
          // accepted writes land in working RAM only
          ram_wr_q <= 1'b1;
          ram_idx_q <= cmd_idx;
          ram_data_q <= cmd_data;
          cmd_accept_q <= 1'b1;
        end
      end
    end
  end
endmodule

// ### verif/pmbus_host_model.sv
// configuring host: command writes, commit strobes, channel limits
`timescale 1ns/1ps
module pmbus_host_model #(
  parameter NF = 4,
  parameter W = 12
) (
  input wire clk,
  output reg cmd_wr,
  output reg [7:0] cmd_idx,
  output reg [47:0] cmd_data,
  output reg commit,
  output reg [NF*W-1:0] fault_limit,
  output reg [NF*W-1:0] fault_hyst
);
  // idle limits at full scale so unused channels never trip
  initial begin
    cmd_wr = 1'b0;
    cmd_idx = 8'h00;
    cmd_data = 48'h0;
    commit = 1'b0;
    fault_limit = {NF*W{1'b1}};
    fault_hyst = {NF*W{1'b0}};
  end
  // held over one taking edge; idle lines then show the inverse, not a stale copy
  task write(input [7:0] idx, input [47:0] data);
    begin
      @(negedge clk);
      cmd_wr = 1'b1;
      cmd_idx = idx;
      cmd_data = data;
      @(negedge clk);
      cmd_wr = 1'b0;
      cmd_idx = ~idx;
      cmd_data = ~data;
    end
  endtask
  task pulse_commit;
    begin
      @(negedge clk);
      commit = 1'b1;
      @(negedge clk);
      commit = 1'b0;
    end
  endtask
  // fault threshold kept strictly past the warning level
  task set_lim(input integer ch, input [W-1:0] warn, input [W-1:0] hy);
    begin
      fault_limit[ch*W +: W] = warn + 12'h010;
      fault_hyst[ch*W +: W] = hy;
    end
  endtask
endmodule

// ### verif/power_fault_protection_chk.sv
// port checker for the fault protection top
`timescale 1ns/1ps
module power_fault_protection_chk #(
  parameter W = 12
) (
  input wire clk,
  input wire rst,
  input wire sample_en,
  input wire sw_cycle,
  input wire [W-1:0] current_sample,
  input wire [W-1:0] short_circuit_threshold,
  input wire [4:0] common_fault_in,
  input wire [4:0] common_shutdown_en,
  input wire cmd_wr,
  input wire [7:0] cmd_idx,
  input wire [47:0] cmd_data,
  input wire commit,
  input wire cmd_accept_q,
  input wire cml_invalid_q,
  input wire [47:0] ram_data_q,
  input wire [7:0] ram_idx_q,
  input wire ram_wr_q,
  input wire otp_commit_q,
  input wire short_circuit_q,
  input wire fast_oc_q,
  input wire converter_on_q
);
  // ==========
  // single domain, so reset disables all checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_answer; cmd_wr |=> cmd_accept_q != cml_invalid_q; endproperty
  a_answer: assert property (p_answer) else $error("write got no single answer");
  property p_cause; cmd_accept_q || cml_invalid_q |-> $past(cmd_wr); endproperty
  a_cause: assert property (p_cause) else $error("answer without write");
  property p_refuse; cml_invalid_q |-> !ram_wr_q; endproperty
  a_refuse: assert property (p_refuse) else $error("refused write reached ram");
  property p_ram; ram_wr_q |-> cmd_accept_q && ram_idx_q == $past(cmd_idx) && ram_data_q == $past(cmd_data); endproperty
  a_ram: assert property (p_ram) else $error("ram word differs from write");
  property p_commit; otp_commit_q |-> $past(commit); endproperty
  a_commit: assert property (p_commit) else $error("commit without request");
  property p_sc_trip; sample_en && short_circuit_threshold != 0 && current_sample > short_circuit_threshold
    |-> ##[1:3] short_circuit_q; endproperty
  a_sc_trip: assert property (p_sc_trip) else $error("short circuit missed");
  property p_sc_off; $rose(short_circuit_q) |-> $past(short_circuit_threshold) != 0; endproperty
  a_sc_off: assert property (p_sc_off) else $error("short circuit while disabled");
  property p_fast; $rose(fast_oc_q) |-> $past(sw_cycle); endproperty
  a_fast: assert property (p_fast) else $error("fast overcurrent off cycle end");
  property p_common; (common_fault_in & common_shutdown_en & 5'h1C) != 5'h00 |-> ##[1:3] !converter_on_q; endproperty
  a_common: assert property (p_common) else $error("common fault did not stop");
endmodule
bind power_fault_protection power_fault_protection_chk #(.W(W)) u_chk (.clk, .rst, .sample_en, .sw_cycle,
  .current_sample, .short_circuit_threshold, .common_fault_in, .common_shutdown_en, .cmd_wr, .cmd_idx,
  .cmd_data, .commit, .cmd_accept_q, .cml_invalid_q, .ram_data_q, .ram_idx_q, .ram_wr_q, .otp_commit_q,
  .short_circuit_q, .fast_oc_q, .converter_on_q);

// ### verif/tb_power_fault_protection.sv
// self-checking bench for the fault protection top
`timescale 1ns/1ps
`include "power_fault_defs.vh"
module tb_power_fault_protection;
  localparam W = 12;
  reg clk = 0;
  reg rst = 1;
  reg sample_en = 0;
  reg sw_cycle = 0;
  reg reenable = 0;
  reg [47:0] fault_value = 0;
  reg [3:0] fault_over = 4'hF;
  reg [15:0] fault_need = 0;
  reg [7:0] fault_resp = 0;
  reg [11:0] fault_retries = 0;
  reg [31:0] fault_delay = 0;
  reg [3:0] fault_is_iin = 4'h2;
  reg [3:0] fault_is_vin = 4'h0;
  reg [3:0] vin_unit_sel = 4'h0;
  reg [3:0] other_unit_sel = 4'h3;
  reg [W-1:0] current_sample = 0;
  reg [W-1:0] short_circuit_threshold = 0;
  reg [W-1:0] fast_overcurrent_limit = 12'h064;
  reg [3:0] fast_overcurrent_count = 4'h8;
  reg [4:0] common_fault_in = 0;
  reg [4:0] common_shutdown_en = 0;
  reg [15:0] write_protect_mask = 16'h0008;
  wire cmd_wr, commit, cmd_accept_q, cml_invalid_q, ram_wr_q, otp_commit_q, short_circuit_q, fast_oc_q, converter_on_q;
  wire [7:0] cmd_idx, ram_idx_q;
  wire [47:0] cmd_data, unlock_read_q, ram_data_q, fault_limit, fault_hyst;
  wire [3:0] fault_flag_q, latched_q;
  integer failures = 0;
  integer n_tests = 0;
  integer k, n, t;
  reg [47:0] pw, d;
  reg [63:0] r;
  power_fault_protection u_dut (.clk, .rst, .sample_en, .sw_cycle, .fault_value, .fault_limit, .fault_hyst,
    .fault_over, .fault_need, .fault_resp, .fault_retries, .fault_delay, .fault_is_iin, .fault_is_vin,
    .vin_unit_sel, .other_unit_sel, .current_sample, .short_circuit_threshold, .fast_overcurrent_limit,
    .fast_overcurrent_count, .common_fault_in, .common_shutdown_en, .reenable, .cmd_wr, .cmd_idx, .cmd_data,
    .unlock_idx(8'h20), .setpw_idx(8'h21), .write_protect_mask, .commit, .unlock_read_q, .cmd_accept_q,
    .cml_invalid_q, .ram_data_q, .ram_idx_q, .ram_wr_q, .otp_commit_q, .fault_flag_q, .short_circuit_q,
    .fast_oc_q, .converter_on_q, .latched_q);
  pmbus_host_model u_host (.clk, .cmd_wr, .cmd_idx, .cmd_data, .commit, .fault_limit, .fault_hyst);
  // ==========
  // clock, helpers, expectations
  always #50 clk = ~clk;
  function integer dly_cyc(input integer cnt, input integer sel);
    dly_cyc = cnt * (`UNIT_BASE_CYC << sel);
  endfunction
  function sc_hit(input [W-1:0] s, input [W-1:0] th);
    sc_hit = (th != 0) && (s > th);
  endfunction
  task check(input [63:0] seen, input [63:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (failures == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task cycles(input integer c);
    repeat (c) @(negedge clk);
  endtask
  task do_reset;
    begin
      rst = 1;
      cycles(8);
      rst = 0;
      cycles(2);
    end
  endtask
  // one idle edge first so back-to-back calls never rewrite the enable in one step
  task samples(input integer c);
    begin
      cycles(1);
      sample_en = 1;
      cycles(c);
      sample_en = 0;
    end
  endtask
  task sw(input integer c);
    repeat (c) begin
      cycles(1);
      sw_cycle = 1;
      cycles(1);
      sw_cycle = 0;
    end
  endtask
  // hang guard sized well past the longest delay scenario
  initial begin
    #(100 * 80000);
    failures = failures + 1;
    report_and_stop;
  end
  // ==========
  // scenarios
  initial begin
    pw = {16'h0000, $urandom(62)};
    do_reset;
    check(unlock_read_q, 48'h0);
    r = {$urandom, $urandom};
    d = r[47:0];
    u_host.write(8'h03, d);
    check({cmd_accept_q, ram_wr_q, ram_idx_q, ram_data_q}, {2'b11, 8'h03, d});
    r = {$urandom, $urandom};
    pw = r[47:0] | 48'h000000000001;
    u_host.write(8'h21, pw);
    cycles(1);
    check(unlock_read_q, 48'h000000000001);
    u_host.write(8'h03, ~d);
    check({cml_invalid_q, ram_wr_q}, 2'b10);
    k = (($urandom % 15) + 4) & 15;
    u_host.write(k[7:0], d);
    check(cmd_accept_q, 1'b1);
    u_host.write(8'h20, pw);
    cycles(1);
    check(unlock_read_q, 48'h0);
    u_host.write(8'h03, d);
    check(cmd_accept_q, 1'b1);
    u_host.pulse_commit;
    check(otp_commit_q, 1'b1);
    // zero threshold: full-scale samples must not trip; fast count broken by one good cycle
    do_reset;
    current_sample = 12'hFFF;
    sample_en = 1;
    sw(5);
    current_sample = 12'h010;
    sw(1);
    current_sample = 12'h0C8;
    sw(9);
    check({short_circuit_q, fast_oc_q}, 2'b00);
    sw(1);
    sample_en = 0;
    check(fast_oc_q, 1'b1);
    do_reset;
    t = ($urandom % 2900) + 100;
    short_circuit_threshold = t[11:0];
    current_sample = t[11:0];
    samples(1);
    check(short_circuit_q, sc_hit(t[11:0], t[11:0]));
    common_shutdown_en = 5'h01;
    current_sample = t[11:0] + 12'h001;
    samples(1);
    check(short_circuit_q, sc_hit(t[11:0] + 12'h001, t[11:0]));
    cycles(3);
    check({short_circuit_q, converter_on_q}, 2'b00);
    common_shutdown_en = 0;
    // input bit 1 is not a common fault input: its slot carries the fast overcurrent
    for (k = 2; k < 10; k = k + 1) begin
      do_reset;
      common_shutdown_en[(k/2 == 1) ? 0 : k/2] = k[0];
      common_fault_in[(k/2 == 1) ? 0 : k/2] = 1'b1;
      cycles(4);
      check(converter_on_q, !k[0]);
      common_fault_in = 0;
      common_shutdown_en = 0;
    end
    // counted channel 0, ignore response
    do_reset;
    u_host.set_lim(0, 12'h3D8, 12'h010);
    u_host.set_lim(1, 12'h3D8, 12'h010);
    n = ($urandom % 4) + 1;
    fault_need[3:0] = n[3:0];
    fault_value[11:0] = 12'h44C;
    samples(n);
    fault_value[11:0] = 12'h384;
    samples(1);
    fault_value[11:0] = 12'h44C;
    samples(n);
    cycles(2);
    check(fault_flag_q[0], 1'b0);
    samples(1);
    cycles(2);
    check({fault_flag_q[0], converter_on_q}, 2'b11);
    // channel 1 runs for four input-voltage units, then latches off
    fault_resp[3:2] = 2'h1;
    fault_delay[15:8] = 8'h04;
    fault_value[23:12] = 12'h44C;
    samples(1);
    cycles(dly_cyc(3, 0) - 1000);
    check(converter_on_q, 1'b1);
    cycles(dly_cyc(1, 0) + 2000);
    check({converter_on_q, latched_q[1]}, 2'b01);
    fault_value = 0;
    samples(1);
    reenable = 1;
    cycles(4);
    reenable = 0;
    cycles(4);
    check(latched_q, 4'h0);
    report_and_stop;
  end
endmodule
